// *** common/tps_pkg.sv ***
package tps_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int OVH_XY_NS       = 2500;
	localparam int OVH_XYZ_NS      = 4750;
	localparam int OVH_HOST_NS     = 2125;
	localparam int OVH_TEMP_NS     = 2625;
	localparam int CONV_FIX_NS     = 4400;
	localparam int SETTLE_UNIT_NS  = 1000;
	localparam int PRE_UNIT_NS     = 250;
	localparam int SNS_UNIT_NS     = 250;
	localparam int CONV_DIV_BASE   = 4;
	localparam int OVH_XY_CYC      = (OVH_XY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVH_XYZ_CYC     = (OVH_XYZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVH_HOST_CYC    = (OVH_HOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVH_TEMP_CYC    = (OVH_TEMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_FIX_CYC    = (CONV_FIX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRE_UNIT_CYC    = (PRE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SNS_UNIT_CYC    = (SNS_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register indexes
	localparam logic [3:0] ADDR_Y      = 4'h0;
	localparam logic [3:0] ADDR_X      = 4'h1;
	localparam logic [3:0] ADDR_Z1     = 4'h2;
	localparam logic [3:0] ADDR_Z2     = 4'h3;
	localparam logic [3:0] ADDR_T1     = 4'h4;
	localparam logic [3:0] ADDR_T2     = 4'h5;
	localparam logic [3:0] ADDR_CTRL   = 4'h6;
	localparam logic [3:0] ADDR_CFG    = 4'h7;
	localparam logic [3:0] ADDR_DRV    = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'h9;
	localparam int         NUM_RESULTS = 6;
	localparam int         CMD_READ_BIT = 15;
	localparam logic [15:0] UNMAPPED_READ = 16'hFFFF;
	localparam logic [15:0] CTRL_RESET    = 16'h0001;
	localparam logic [15:0] CFG_RESET     = 16'h0000;
	localparam logic [15:0] RESULT_RESET  = 16'h0000;
	localparam int         RES_W = 12;

	// ==========================================================
	// Control fields: fn in [2:0], mode in [5:4]
	localparam int FN_LSB   = 0;
	localparam int MODE_LSB = 4;
	localparam logic [1:0] MODE_AUTO      = 2'h0;
	localparam logic [1:0] MODE_HOST_INIT = 2'h1;
	localparam logic [1:0] MODE_HOST_CTRL = 2'h2;
	localparam logic [2:0] FN_NONE = 3'h0;
	localparam logic [2:0] FN_XY   = 3'h1;
	localparam logic [2:0] FN_XYZ  = 3'h2;
	localparam logic [2:0] FN_X    = 3'h3;
	localparam logic [2:0] FN_Y    = 3'h4;
	localparam logic [2:0] FN_Z    = 3'h5;
	localparam logic [2:0] FN_T1   = 3'h6;
	localparam logic [2:0] FN_T2   = 3'h7;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [1:0] conv_div;
		logic [1:0] res;
		logic [1:0] avg;
		logic [2:0] sns;
		logic [2:0] pre;
		logic [3:0] settle;
	} tps_cfg_s;

	typedef struct packed {
		logic temp_high;
		logic temp_sel;
		logic z;
		logic x;
		logic y;
	} tps_drv_s;

	typedef enum {TPS_C_Y, TPS_C_X, TPS_C_Z1, TPS_C_Z2, TPS_C_T1, TPS_C_T2} tps_coord_e;
	typedef enum {TPS_S_IDLE, TPS_S_OVH, TPS_S_ENTER, TPS_S_SETTLE, TPS_S_PRE, TPS_S_SENSE,
		TPS_S_CLOAD, TPS_S_CONV, TPS_S_STORE} tps_state_e;

endpackage : tps_pkg

// *** logic/tps_seq.sv ***
`timescale 1ns/10ps
`default_nettype none

module tps_seq
	import tps_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        spi_sclk_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_mosi_i,
	output logic             spi_miso_o,
	input  wire logic        pen_touch_i,
	input  wire logic [11:0] adc_data_i,
	output logic             pen_touch_irq_n_o,
	output logic             conv_clk_en_o,
	output logic             adc_pwr_o,
	output logic             adc_start_o,
	output tps_drv_s         panel_drv_o
);

	// ==========================================================
	// Input synchronisers
	logic        sclk_m, sclk_s, sclk_d;
	logic        cs_m, cs_s;
	logic        mosi_m, mosi_s;
	logic        touch_m, touch_s, touch_d;
	logic [11:0] adc_m, adc_s;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sclk_m  <= 1'b0;
			sclk_s  <= 1'b0;
			sclk_d  <= 1'b0;
			cs_m    <= 1'b1;
			cs_s    <= 1'b1;
			mosi_m  <= 1'b0;
			mosi_s  <= 1'b0;
			touch_m <= 1'b0;
			touch_s <= 1'b0;
			touch_d <= 1'b0;
			adc_m   <= 12'h000;
			adc_s   <= 12'h000;
		end else begin
			sclk_m  <= spi_sclk_i;
			sclk_s  <= sclk_m;
			sclk_d  <= sclk_s;
			cs_m    <= spi_cs_n_i;
			cs_s    <= cs_m;
			mosi_m  <= spi_mosi_i;
			mosi_s  <= mosi_m;
			touch_m <= pen_touch_i;
			touch_s <= touch_m;
			touch_d <= touch_s;
			adc_m   <= adc_data_i;
			adc_s   <= adc_m;
		end
	end

	// ==========================================================
	// Serial port: 16-bit command then 16-bit data, mode 0
	logic [5:0]  bit_cnt;
	logic [15:0] sh_in;
	logic [15:0] sh_out;
	logic        cmd_rd;
	logic [3:0]  cmd_addr;
	logic        wr_en;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic        sclk_rise, sclk_fall;

	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bit_cnt    <= 6'h00;
			sh_in      <= 16'h0000;
			sh_out     <= 16'h0000;
			cmd_rd     <= 1'b0;
			cmd_addr   <= 4'h0;
			wr_en      <= 1'b0;
			wr_data    <= 16'h0000;
			spi_miso_o <= 1'b0;
		end else begin
			wr_en <= 1'b0;
			if (cs_s) begin
				bit_cnt <= 6'h00;
			end else if (sclk_rise) begin
				sh_in   <= {sh_in[14:0], mosi_s};
				bit_cnt <= bit_cnt + 6'h01;
				if (bit_cnt == 6'h0F) begin
					cmd_rd   <= sh_in[CMD_READ_BIT - 1];
					cmd_addr <= {sh_in[2:0], mosi_s};
				end
				if (bit_cnt == 6'h1F && !cmd_rd) begin
					wr_en   <= 1'b1;
					wr_data <= {sh_in[14:0], mosi_s};
				end
			end else if (sclk_fall && bit_cnt >= 6'h10) begin
				if (bit_cnt == 6'h10) begin
					spi_miso_o <= rd_data[15];
					sh_out     <= {rd_data[14:0], 1'b0};
				end else begin
					spi_miso_o <= sh_out[15];
					sh_out     <= {sh_out[14:0], 1'b0};
				end
			end
		end
	end

	// ==========================================================
	// Host registers
	logic [15:0] ctrl;
	tps_cfg_s    cfg;
	tps_drv_s    host_drv;
	logic [2:0]  fn_w;
	logic [1:0]  mode_w;
	logic [1:0]  mode;

	assign fn_w   = wr_data[FN_LSB +: 3];
	assign mode_w = wr_data[MODE_LSB +: 2];
	assign mode   = ctrl[MODE_LSB +: 2];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl     <= CTRL_RESET;
			cfg      <= CFG_RESET;
			host_drv <= '0;
		end else if (wr_en) begin
			if (cmd_addr == ADDR_CTRL) begin
				ctrl <= wr_data;
			end else if (cmd_addr == ADDR_CFG) begin
				cfg <= wr_data;
			end else if (cmd_addr == ADDR_DRV) begin
				host_drv <= wr_data[4:0];
			end
		end
	end

	// ==========================================================
	// Derived timing
	logic [3:0]  res_bits;
	logic [4:0]  avg_cfg;
	logic [2:0]  avg_sh_cfg;
	logic [15:0] conv_len;
	logic [15:0] settle_len;
	logic [15:0] pre_len;
	logic [15:0] sns_len;

	always_comb begin
		case (cfg.res)
			2'h1:    res_bits = 4'h8;
			2'h2:    res_bits = 4'hA;
			default: res_bits = 4'hC;
		endcase
		case (cfg.avg)
			2'h1:    avg_sh_cfg = 3'h2;
			2'h2:    avg_sh_cfg = 3'h3;
			2'h3:    avg_sh_cfg = 3'h4;
			default: avg_sh_cfg = 3'h0;
		endcase
		avg_cfg    = 5'h01 << avg_sh_cfg;
		conv_len   = 16'(CONV_FIX_CYC) + 16'(res_bits) * (16'(CONV_DIV_BASE) << cfg.conv_div);
		settle_len = 16'(SETTLE_UNIT_CYC) * 16'(cfg.settle);
		pre_len    = 16'(PRE_UNIT_CYC) * 16'(cfg.pre);
		sns_len    = 16'(SNS_UNIT_CYC) * 16'(cfg.sns);
	end

	// ==========================================================
	// Scan sequencer
	tps_state_e  state;
	tps_coord_e  cur;
	logic [2:0]  fn_q;
	logic [15:0] cnt;
	logic [4:0]  conv_left;
	logic [2:0]  avg_sh;
	logic [15:0] acc;
	tps_drv_s    seq_drv;
	logic [15:0] res_q [NUM_RESULTS];
	logic        start_auto, start_cmd, touch_coord;
	logic [2:0]  fn_go;
	logic [15:0] ovh_go;
	logic [11:0] sample;

	assign start_auto = touch_s & ~touch_d & (mode == MODE_AUTO) & (ctrl[2:0] != FN_NONE)
		& (ctrl[2:0] < FN_T1);
	assign start_cmd  = wr_en & (cmd_addr == ADDR_CTRL) & (fn_w != FN_NONE)
		& ((mode_w != MODE_AUTO) | (fn_w >= FN_T1));
	assign fn_go       = start_cmd ? fn_w : ctrl[2:0];
	assign sample      = 12'(adc_s >> (4'hC - res_bits));
	assign touch_coord = (cur == TPS_C_Y) | (cur == TPS_C_X) | (cur == TPS_C_Z1)
		| (cur == TPS_C_Z2);

	always_comb begin
		if (fn_go == FN_XY) begin
			ovh_go = 16'(OVH_XY_CYC);
		end else if (fn_go == FN_XYZ) begin
			ovh_go = 16'(OVH_XYZ_CYC);
		end else if (fn_go >= FN_T1) begin
			ovh_go = 16'(OVH_TEMP_CYC);
		end else begin
			ovh_go = 16'(OVH_HOST_CYC);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state         <= TPS_S_IDLE;
			cur           <= TPS_C_Y;
			fn_q          <= FN_NONE;
			cnt           <= 16'h0000;
			conv_left     <= 5'h00;
			avg_sh        <= 3'h0;
			acc           <= 16'h0000;
			seq_drv       <= '0;
			conv_clk_en_o <= 1'b0;
			adc_pwr_o     <= 1'b0;
			adc_start_o   <= 1'b0;
			for (int i = 0; i < NUM_RESULTS; i++) begin
				res_q[i] <= RESULT_RESET;
			end
		end else begin
			adc_start_o <= 1'b0;
			case (state)
				TPS_S_IDLE: begin
					if (start_auto || start_cmd) begin
						state         <= TPS_S_OVH;
						fn_q          <= fn_go;
						cnt           <= ovh_go;
						conv_clk_en_o <= 1'b1;
						if (fn_go == FN_X) begin
							cur <= TPS_C_X;
						end else if (fn_go == FN_Z) begin
							cur <= TPS_C_Z1;
						end else if (fn_go >= FN_T1) begin
							cur <= TPS_C_T1;
						end else begin
							cur <= TPS_C_Y;
						end
					end
				end
				TPS_S_OVH: begin
					if (cnt <= 16'h0001) begin
						state <= TPS_S_ENTER;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				TPS_S_ENTER: begin
					acc       <= 16'h0000;
					conv_left <= touch_coord ? avg_cfg : 5'h01;
					avg_sh    <= touch_coord ? avg_sh_cfg : 3'h0;
					cnt       <= settle_len;
					state     <= TPS_S_SETTLE;
					case (cur)
						TPS_C_Y:  seq_drv <= tps_drv_s'(5'h01);
						TPS_C_X:  seq_drv <= tps_drv_s'(5'h02);
						TPS_C_Z1: seq_drv <= tps_drv_s'(5'h04);
						TPS_C_Z2: state   <= TPS_S_CLOAD;
						TPS_C_T1: begin
							seq_drv <= tps_drv_s'(5'h08);
							state   <= TPS_S_CLOAD;
						end
						default: begin
							seq_drv <= tps_drv_s'(5'h18);
							state   <= TPS_S_CLOAD;
						end
					endcase
				end
				TPS_S_SETTLE: begin
					if (cnt > 16'h0001) begin
						cnt <= cnt - 16'h0001;
					end else if (mode == MODE_HOST_CTRL) begin
						state <= TPS_S_CLOAD;
					end else begin
						cnt   <= pre_len;
						state <= TPS_S_PRE;
					end
				end
				TPS_S_PRE: begin
					if (cnt > 16'h0001) begin
						cnt <= cnt - 16'h0001;
					end else begin
						cnt   <= sns_len;
						state <= TPS_S_SENSE;
					end
				end
				TPS_S_SENSE: begin
					if (cnt > 16'h0001) begin
						cnt <= cnt - 16'h0001;
					end else if (!touch_s) begin
						state         <= TPS_S_IDLE;
						seq_drv       <= '0;
						conv_clk_en_o <= 1'b0;
					end else begin
						state <= TPS_S_CLOAD;
					end
				end
				TPS_S_CLOAD: begin
					cnt         <= conv_len - 16'h0001;
					adc_start_o <= 1'b1;
					adc_pwr_o   <= 1'b1;
					state       <= TPS_S_CONV;
				end
				TPS_S_CONV: begin
					if (cnt > 16'h0001) begin
						cnt <= cnt - 16'h0001;
					end else begin
						acc       <= acc + 16'(sample);
						conv_left <= conv_left - 5'h01;
						state     <= (conv_left == 5'h01) ? TPS_S_STORE : TPS_S_CLOAD;
					end
				end
				default: begin
					adc_pwr_o  <= 1'b0;
					res_q[cur] <= {4'h0, 12'(acc >> avg_sh)};
					state      <= TPS_S_IDLE;
					if (touch_coord && mode != MODE_HOST_CTRL && !touch_s) begin
						state <= TPS_S_IDLE;
					end else if (cur == TPS_C_Y && (fn_q == FN_XY || fn_q == FN_XYZ)) begin
						cur   <= TPS_C_X;
						state <= TPS_S_ENTER;
					end else if (cur == TPS_C_X && fn_q == FN_XYZ) begin
						cur   <= TPS_C_Z1;
						state <= TPS_S_ENTER;
					end else if (cur == TPS_C_Z1) begin
						cur   <= TPS_C_Z2;
						state <= TPS_S_ENTER;
					end else if (cur == TPS_C_T1 && fn_q == FN_T2) begin
						cur   <= TPS_C_T2;
						state <= TPS_S_ENTER;
					end
					if (state == TPS_S_STORE && !((cur == TPS_C_Y && (fn_q == FN_XY
						|| fn_q == FN_XYZ)) || (cur == TPS_C_X && fn_q == FN_XYZ)
						|| cur == TPS_C_Z1 || (cur == TPS_C_T1 && fn_q == FN_T2))
						|| (touch_coord && mode != MODE_HOST_CTRL && !touch_s)) begin
						seq_drv       <= '0;
						conv_clk_en_o <= 1'b0;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Pen interrupt and driver outputs
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pen_touch_irq_n_o <= 1'b1;
			panel_drv_o       <= '0;
		end else begin
			pen_touch_irq_n_o <= ~touch_s;
			if (mode == MODE_HOST_CTRL && state == TPS_S_IDLE) begin
				panel_drv_o <= host_drv;
			end else begin
				panel_drv_o <= seq_drv;
			end
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		if (cmd_addr <= ADDR_T2) begin
			rd_data = res_q[cmd_addr[2:0]];
		end else if (cmd_addr == ADDR_CTRL) begin
			rd_data = ctrl;
		end else if (cmd_addr == ADDR_CFG) begin
			rd_data = cfg;
		end else if (cmd_addr == ADDR_DRV) begin
			rd_data = {11'h000, host_drv};
		end else if (cmd_addr == ADDR_STATUS) begin
			rd_data = {14'h0000, touch_s, state != TPS_S_IDLE};
		end else begin
			rd_data = UNMAPPED_READ;
		end
	end

endmodule : tps_seq

`default_nettype wire

// *** verif/tps_seq_properties.sv ***
`timescale 1ns/10ps
`default_nettype none

module tps_seq_properties
	import tps_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        spi_sclk_i,
	input wire logic        spi_cs_n_i,
	input wire logic        spi_mosi_i,
	input wire logic        spi_miso_o,
	input wire logic        pen_touch_i,
	input wire logic [11:0] adc_data_i,
	input wire logic        pen_touch_irq_n_o,
	input wire logic        conv_clk_en_o,
	input wire logic        adc_pwr_o,
	input wire logic        adc_start_o,
	input wire tps_drv_s    panel_drv_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ====
	// Cycle counts since driver change and since conversion start
	logic [15:0] since_drv;
	logic [15:0] since_start;
	tps_drv_s    drv_q;
	logic        touch_conv;

	assign touch_conv = adc_start_o && !panel_drv_o.temp_sel && !panel_drv_o.temp_high;

	always_ff @(posedge clk_i) begin
		drv_q <= panel_drv_o;
		if (!rst_n_i || panel_drv_o != drv_q) since_drv <= '0;
		else if (since_drv != 16'hFFFF) since_drv <= since_drv + 16'h1;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) since_start <= 16'hFFFF;
		else if (adc_start_o) since_start <= 16'h1;
		else if (since_start != 16'hFFFF) since_start <= since_start + 16'h1;
	end

	// ====
	// Sequences
	sequence s_conv_run;
		(adc_pwr_o && conv_clk_en_o)[*8];
	endsequence

	sequence s_released;
		(pen_touch_irq_n_o && !panel_drv_o.temp_sel && !panel_drv_o.temp_high)[*8];
	endsequence

	// ====
	// Properties
	AST_IRQ_LOW: assert property (pen_touch_i[*6] |-> !pen_touch_irq_n_o)
		else $error("pen interrupt high while touched");
	AST_IRQ_HIGH: assert property (!pen_touch_i[*6] |-> pen_touch_irq_n_o)
		else $error("pen interrupt low while untouched");
	AST_SETTLE: assert property (touch_conv |-> since_drv >= 16'(SETTLE_UNIT_CYC))
		else $error("conversion before panel settled");
	AST_CONV_GAP: assert property (adc_start_o |-> since_start >= 16'(CONV_FIX_CYC))
		else $error("conversion shorter than fixed part");
	AST_CONV_RUN: assert property (adc_start_o |-> conv_clk_en_o ##1 s_conv_run)
		else $error("converter not powered during conversion");
	AST_PWR_CLK: assert property (adc_pwr_o |-> conv_clk_en_o)
		else $error("converter powered without conversion clock");
	AST_END: assert property ($fell(conv_clk_en_o) |-> !adc_pwr_o && !adc_start_o)
		else $error("scan ended with converter active");
	AST_RELEASE: assert property (s_released |-> !adc_start_o)
		else $error("conversion started after release");
	AST_ONE_AXIS: assert property (!(panel_drv_o.x && panel_drv_o.y))
		else $error("both axes driven");
	AST_HIGH_CUR: assert property ($rose(panel_drv_o.temp_high) |-> conv_clk_en_o)
		else $error("raised current outside a scan");
endmodule : tps_seq_properties

bind tps_seq tps_seq_properties u_props (
	.clk_i             (clk_i),
	.rst_n_i           (rst_n_i),
	.spi_sclk_i        (spi_sclk_i),
	.spi_cs_n_i        (spi_cs_n_i),
	.spi_mosi_i        (spi_mosi_i),
	.spi_miso_o        (spi_miso_o),
	.pen_touch_i       (pen_touch_i),
	.adc_data_i        (adc_data_i),
	.pen_touch_irq_n_o (pen_touch_irq_n_o),
	.conv_clk_en_o     (conv_clk_en_o),
	.adc_pwr_o         (adc_pwr_o),
	.adc_start_o       (adc_start_o),
	.panel_drv_o       (panel_drv_o)
);

`default_nettype wire

// *** verif/tps_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module tps_host_model
	import tps_pkg::*;
(
	input  wire logic clk_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// ====
	// Half serial period, off the system edge
	task automatic half;
		repeat (10) @(posedge clk_i);
		#1;
	endtask : half

	// ====
	// Command word then data word, msb first
	task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = '0;
		cs_n_o = 1'b0;
		for (int i = 0; i < 32; i++) begin
			mosi_o = sh[31 - i];
			half();
			if (i >= 16) rd = {rd[14:0], miso_i};
			sclk_o = 1'b1;
			half();
			sclk_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		half();
	endtask : xfer
endmodule : tps_host_model

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb
	import tps_pkg::*;
;
	logic        clk_i;
	logic        rst_n_i;
	logic        sclk;
	logic        cs_n;
	logic        mosi;
	logic        miso;
	logic        touch;
	logic [11:0] adc;
	logic        irq_n;
	logic        clk_en;
	logic        pwr;
	logic        start;
	tps_drv_s    drv;
	int          n_hi = 0;
	int          h0;
	logic        irq_q = 1'b1;
	logic        en_q = 1'b0;
	int          failures = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n_start = 0;
	int          dur = 0;
	int          irq_fall = 0;
	int          en_rise = 0;
	int          d0;
	int          n0;

	tps_seq u_dut (
		.clk_i             (clk_i),
		.rst_n_i           (rst_n_i),
		.spi_sclk_i        (sclk),
		.spi_cs_n_i        (cs_n),
		.spi_mosi_i        (mosi),
		.spi_miso_o        (miso),
		.pen_touch_i       (touch),
		.adc_data_i        (adc),
		.pen_touch_irq_n_o (irq_n),
		.conv_clk_en_o     (clk_en),
		.adc_pwr_o         (pwr),
		.adc_start_o       (start),
		.panel_drv_o       (drv)
	);

	tps_host_model u_host (
		.clk_i  (clk_i),
		.sclk_o (sclk),
		.cs_n_o (cs_n),
		.mosi_o (mosi),
		.miso_i (miso)
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ====
	// Monitor and hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		irq_q <= irq_n;
		en_q <= clk_en;
		if (start) n_start <= n_start + 1;
		if (clk_en) dur <= dur + 1;
		if (irq_q && !irq_n) irq_fall <= cyc;
		if (!en_q && clk_en) en_rise <= cyc;
		if (drv.temp_high) n_hi <= n_hi + 1;
		if (cyc == 80000) begin
			failures++;
			$display("unexpected %0t timeout", $time);
			tally_and_finish();
		end
	end

	// ====
	// Tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] r;
		u_host.xfer({12'h000, a}, d, r);
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string w);
		logic [15:0] r;
		u_host.xfer({1'b1, 11'h000, a}, 16'h0000, r);
		chk(r, e, w);
	endtask : rd_chk

	task automatic mark;
		d0 = dur;
		n0 = n_start;
		h0 = n_hi;
	endtask : mark

	task automatic scan(input int lo, input int hi, input int n_exp, input string w);
		int t;
		for (t = 0; t < 3000 && !clk_en; t++) step(1);
		for (t = 0; t < 20000 && clk_en; t++) step(1);
		chk(16'(n_start - n0), 16'(n_exp), {w, " conversions"});
		if (hi > 0) chk({15'h0, (dur - d0 >= lo) && (dur - d0 <= hi)}, 16'h0001, {w, " time"});
		$display("test %s done", w);
	endtask : scan

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// ====
	// Tests
	initial begin
		rst_n_i = 1'b0;
		touch = 1'b0;
		adc = 12'hA5C;
		repeat (10) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		step(4);
		rd_chk(ADDR_Y, RESULT_RESET, "y reset");
		rd_chk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
		rd_chk(ADDR_CFG, CFG_RESET, "cfg reset");
		rd_chk(4'hA, UNMAPPED_READ, "unmapped");
		wr(ADDR_Y, 16'h1234);
		rd_chk(ADDR_Y, RESULT_RESET, "y read only");
		wr(ADDR_CFG, 16'h4091);
		mark();
		touch = 1'b1;
		scan(1983, 1999, 2, "auto xy");
		chk(16'(irq_fall), 16'(en_rise), "clock with irq");
		chk({15'h0, irq_n}, 16'h0000, "irq");
		rd_chk(ADDR_Y, 16'h0A5C, "y");
		rd_chk(ADDR_X, 16'h0A5C, "x");
		rd_chk(ADDR_STATUS, 16'h0002, "status touched idle");
		touch = 1'b0;
		wr(ADDR_CTRL, 16'h0002);
		wr(ADDR_CFG, 16'h1491);
		mark();
		touch = 1'b1;
		scan(10473, 10489, 16, "auto xyz");
		for (int i = 0; i < 4; i++) rd_chk(ADDR_Y + 4'(i), 16'h00A5, "xyz result");
		touch = 1'b0;
		wr(ADDR_CTRL, 16'h0001);
		wr(ADDR_CFG, 16'h0091);
		adc = 12'h777;
		mark();
		touch = 1'b1;
		for (int t = 0; t < 2000 && n_start == n0; t++) step(1);
		touch = 1'b0;
		scan(0, 0, 1, "release");
		rd_chk(ADDR_X, 16'h00A5, "x kept");
		wr(ADDR_CTRL, 16'h0010);
		mark();
		touch = 1'b1;
		step(400);
		chk({14'h0, irq_n, clk_en}, 16'h0000, "host init idle");
		wr(ADDR_CTRL, 16'h0014);
		scan(0, 0, 1, "host init y");
		rd_chk(ADDR_Y, 16'h0777, "host init y");
		wr(ADDR_CTRL, 16'h0020);
		wr(ADDR_CFG, 16'h2002);
		wr(ADDR_DRV, 16'h0001);
		step(8);
		chk({11'h0, drv}, 16'h0001, "host drivers");
		mark();
		wr(ADDR_CTRL, 16'h0024);
		scan(1106, 1122, 1, "host ctrl");
		rd_chk(ADDR_Y, 16'h01DD, "host ctrl y");
		touch = 1'b0;
		wr(ADDR_DRV, 16'h0000);
		wr(ADDR_CFG, 16'h0091);
		adc = 12'h123;
		mark();
		wr(ADDR_CTRL, 16'h0006);
		scan(0, 0, 1, "temp base");
		rd_chk(ADDR_T1, 16'h0123, "t1");
		adc = 12'h456;
		mark();
		wr(ADDR_CTRL, 16'h0007);
		scan(0, 0, 2, "temp high");
		chk({15'h0, n_hi > h0}, 16'h0001, "raised current");
		rd_chk(ADDR_T2, 16'h0456, "t2");
		tally_and_finish();
	end
endmodule : tb

`default_nettype wire
